// File: design/uartfp_defines.svh
`ifndef UARTFP_DEFINES_SVH
`define UARTFP_DEFINES_SVH
// ==========================================================
// Register map: channel select bit and word index in address
`define UFP_CH_BIT 5
`define UFP_IDX_HI 4
`define UFP_IDX_LO 2
`define UFP_MAP_HI 31
`define UFP_MAP_LO 6
`define UFP_IDX_MODE 3'h0
`define UFP_IDX_TXS 3'h1
`define UFP_IDX_RXB 3'h2
`define UFP_IDX_ERR 3'h3
`define UFP_IDX_BAUD 3'h4
`define UFP_IDX_FLAG 3'h5
// ==========================================================
// Mode register fields
`define UFP_B_TXE 7
`define UFP_B_RXE 6
`define UFP_B_PHI 5
`define UFP_B_PLO 4
`define UFP_B_CL 3
`define UFP_B_SL 2
`define UFP_B_MASK 1
`define UFP_PAR_NONE 2'h0
`define UFP_PAR_ZERO 2'h1
`define UFP_PAR_ODD 2'h2
`define UFP_PAR_EVEN 2'h3
// ==========================================================
// Baud register fields and limits
`define UFP_K_HI 7
`define UFP_M_HI 11
`define UFP_M_LO 8
`define UFP_K_MIN 8'h08
`define UFP_M_MAX 4'h9
// ==========================================================
// Error codes, flag bits, reset values
`define UFP_ERR_PE 8'h04
`define UFP_ERR_FE 8'h02
`define UFP_ERR_OE 8'h01
`define UFP_F_TXPEND 0
`define UFP_F_TXBUSY 1
`define UFP_F_RXFULL 2
`define UFP_RST_8 8'h00
`define UFP_RST_M 4'h0
`define UFP_LAST7 3'h6
`define UFP_LAST8 3'h7
`endif

// File: design/uartfp_pkg.sv
package uartfp_pkg;
  // Transmitter and receiver sequencing
  typedef enum logic [2:0] {UFP_IDLE, UFP_START, UFP_DATA, UFP_PAR, UFP_STOP} uartfp_st_e;
  // Register access toward one channel
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] idx;
    logic [31:0] wdata;
  } uartfp_req_s;
  // Per-channel event pulses
  typedef struct packed {
    logic tx_done_irq;
    logic rx_done_irq;
    logic rx_error_irq;
  } uartfp_irq_s;
endpackage

// File: design/uartfp_top.sv
// Functional notes
// - Even parity transmit: parity bit is XOR of data bits.
// - Even parity receive: odd ones count in data plus parity flags error.
// - Odd parity transmit: parity bit is inverted XOR of data.
// - Odd parity receive: even ones count in data plus parity flags error.
// - Zero parity sends 0 and never checks received parity.
// - No parity: no parity bit sent or expected, no parity error.
// - Writing transmit shift register starts framed transmission.
// - Frame sent raises transmit done pulse and sets pending flag.
// - Receiver runs only while receive enable is set.
// - Falling edge starts counter; half-bit low sample confirms start.
// - Receiver checks one stop bit, even with two configured.
// - Frame end loads receive buffer and raises receive done.
// - Buffer is loaded even when the frame has errors.
// - Error frames raise receive done only when mask bit is clear.
// - Clearing receive enable aborts at once without any update or event.
// - Error event precedes receive done of the same frame.
// - Error codes: parity 04H, framing 02H, overrun 01H.
// - Error status clears on buffer read or next frame.
// - Clock stop freezes settings, transmit level and partial reception; buffer reads and flag writes still clear status.
// - Seven-bit mode ignores transmit bit 7 and reads received bit 7 as 0.
// - Enable bits choose stop, receive, transmit or both; pins revert.
// - Bit time is 2^(m+1) times k main clocks, k from 8 to 255.
//
// Local design decisions: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "uartfp_defines.svh"

// ==========================================================
// One serial channel
module uartfp_chan
  import uartfp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_stop,
  input wire uartfp_req_s req,
  output logic [31:0] rdata,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic [1:0] pin_serial,
  output uartfp_irq_s irq
);
  logic [7:0] channel_mode_reg;
  logic [7:0] divisor_k_field;
  logic [3:0] prescale_m_field;
  logic [7:0] tx_shift_reg;
  logic [7:0] rx_buffer_reg;
  logic [7:0] rx_error_status_reg;
  logic tx_done_pending_flag;
  logic rx_full_reg;
  uartfp_st_e tx_state_reg;
  uartfp_st_e rx_state_reg;
  logic [10:0] pre_cnt_reg;
  logic [7:0] tx_cnt_reg;
  logic [7:0] rx_cnt_reg;
  logic [2:0] tx_bit_reg;
  logic [2:0] rx_bit_reg;
  logic tx_par_reg;
  logic tx_stop_reg;
  logic rx_par_reg;
  logic rx_prev_reg;
  logic [7:0] rx_sh_reg;
  logic done_dly_reg;
  logic done_err_reg;
  logic tx_enable_bit;
  logic rx_enable_bit;
  logic error_completion_mask;
  logic [1:0] parity_select_field;
  logic char_length_bit;
  logic stop_length_bit;
  logic [3:0] m_eff;
  logic [7:0] k_eff;
  logic [10:0] pre_lim;
  logic tick;
  logic tx_bit_end;
  logic rx_bit_end;
  logic rx_half_end;
  logic [2:0] last_bit;
  logic tx_go;
  logic tx_fin;
  logic rx_fin;
  logic rxb_rd;
  logic [7:0] rx_data;
  logic pe;
  logic fe;
  logic [7:0] err_new;

  assign tx_enable_bit = channel_mode_reg[`UFP_B_TXE];
  assign rx_enable_bit = channel_mode_reg[`UFP_B_RXE];
  assign error_completion_mask = channel_mode_reg[`UFP_B_MASK];
  assign parity_select_field = channel_mode_reg[`UFP_B_PHI:`UFP_B_PLO];
  assign char_length_bit = channel_mode_reg[`UFP_B_CL];
  assign stop_length_bit = channel_mode_reg[`UFP_B_SL];
  assign pin_serial = {tx_enable_bit, rx_enable_bit};

  // ========================================================
  // Bit clock: tick every 2^(m+1) clocks, bit every k ticks
  assign m_eff = (prescale_m_field > `UFP_M_MAX) ? `UFP_M_MAX : prescale_m_field;
  assign k_eff = (divisor_k_field < `UFP_K_MIN) ? `UFP_K_MIN : divisor_k_field;
  assign pre_lim = (11'h001 << (m_eff + 4'h1)) - 11'h001;
  assign tick = (pre_cnt_reg == pre_lim) && !clk_stop;
  assign tx_bit_end = tick && (tx_cnt_reg == k_eff - 8'h01);
  assign rx_bit_end = tick && (rx_cnt_reg == k_eff - 8'h01);
  assign rx_half_end = tick && (rx_cnt_reg == (k_eff >> 1) - 8'h01);
  assign last_bit = char_length_bit ? `UFP_LAST8 : `UFP_LAST7;

  // Prescaler, frozen while the clock is stopped
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt_reg <= 11'h000;
    end else if (!(tx_enable_bit || rx_enable_bit)) begin
      pre_cnt_reg <= 11'h000;
    end else if (!clk_stop) begin
      pre_cnt_reg <= (pre_cnt_reg >= pre_lim) ? 11'h000 : pre_cnt_reg + 11'h001;
    end
  end

  // ========================================================
  // Software registers
  assign rxb_rd = req.rd && (req.idx == `UFP_IDX_RXB);
  assign tx_go = req.wr && (req.idx == `UFP_IDX_TXS) && tx_enable_bit && !clk_stop
    && (tx_state_reg == UFP_IDLE);

  // Mode and baud settings, held during clock stop
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_mode_reg <= `UFP_RST_8;
      divisor_k_field <= `UFP_RST_8;
      prescale_m_field <= `UFP_RST_M;
    end else if (req.wr && !clk_stop) begin
      if (req.idx == `UFP_IDX_MODE) begin
        channel_mode_reg <= {req.wdata[7:1], 1'b0};
      end
      if (req.idx == `UFP_IDX_BAUD) begin
        divisor_k_field <= req.wdata[`UFP_K_HI:0];
        prescale_m_field <= req.wdata[`UFP_M_HI:`UFP_M_LO];
      end
    end
  end

  // Read multiplexer
  always_comb begin
    unique case (req.idx)
      `UFP_IDX_MODE: rdata = {24'h000000, channel_mode_reg};
      `UFP_IDX_TXS: rdata = {24'h000000, tx_shift_reg};
      `UFP_IDX_RXB: rdata = {24'h000000, rx_buffer_reg};
      `UFP_IDX_ERR: rdata = {24'h000000, rx_error_status_reg};
      `UFP_IDX_BAUD: rdata = {20'h00000, prescale_m_field, divisor_k_field};
      `UFP_IDX_FLAG: rdata = {29'h00000000, rx_full_reg, (tx_state_reg != UFP_IDLE),
        tx_done_pending_flag};
      default: rdata = 32'h00000000;
    endcase
  end

  // ========================================================
  // Transmitter
  assign tx_fin = tx_bit_end && (tx_state_reg == UFP_STOP)
    && !(stop_length_bit && !tx_stop_reg);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_reg <= UFP_IDLE;
      tx_shift_reg <= `UFP_RST_8;
      serial_out_pin <= 1'b1;
      tx_cnt_reg <= `UFP_RST_8;
      tx_bit_reg <= 3'h0;
      tx_par_reg <= 1'b0;
      tx_stop_reg <= 1'b0;
    end else if (!tx_enable_bit) begin
      tx_state_reg <= UFP_IDLE;
      serial_out_pin <= 1'b1;
    end else if (tx_go) begin
      tx_shift_reg <= char_length_bit ? req.wdata[7:0] : {1'b0, req.wdata[6:0]};
      unique case (parity_select_field)
        `UFP_PAR_EVEN: tx_par_reg <= ^req.wdata[6:0] ^ (char_length_bit & req.wdata[7]);
        `UFP_PAR_ODD: tx_par_reg <= ~(^req.wdata[6:0] ^ (char_length_bit & req.wdata[7]));
        default: tx_par_reg <= 1'b0;
      endcase
      tx_state_reg <= UFP_START;
      serial_out_pin <= 1'b0;
      tx_cnt_reg <= 8'h00;
      tx_bit_reg <= 3'h0;
      tx_stop_reg <= 1'b0;
    end else if (tick) begin
      tx_cnt_reg <= tx_bit_end ? 8'h00 : tx_cnt_reg + 8'h01;
      if (tx_bit_end) begin
        unique case (tx_state_reg)
          UFP_START: begin
            tx_state_reg <= UFP_DATA;
            serial_out_pin <= tx_shift_reg[0];
          end
          UFP_DATA: begin
            tx_shift_reg <= tx_shift_reg >> 1;
            if (tx_bit_reg == last_bit) begin
              if (parity_select_field == `UFP_PAR_NONE) begin
                tx_state_reg <= UFP_STOP;
                serial_out_pin <= 1'b1;
              end else begin
                tx_state_reg <= UFP_PAR;
                serial_out_pin <= tx_par_reg;
              end
            end else begin
              tx_bit_reg <= tx_bit_reg + 3'h1;
              serial_out_pin <= tx_shift_reg[1];
            end
          end
          UFP_PAR: begin
            tx_state_reg <= UFP_STOP;
            serial_out_pin <= 1'b1;
          end
          UFP_STOP: begin
            tx_stop_reg <= 1'b1;
            if (tx_fin) begin
              tx_state_reg <= UFP_IDLE;
            end
          end
          UFP_IDLE: begin
            serial_out_pin <= 1'b1;
          end
        endcase
      end
    end
  end

  // Transmit done pulse and sticky pending flag, set wins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_done_pending_flag <= 1'b0;
      irq.tx_done_irq <= 1'b0;
    end else begin
      irq.tx_done_irq <= tx_fin && tx_enable_bit;
      if (tx_fin && tx_enable_bit) begin
        tx_done_pending_flag <= 1'b1;
      end else if (req.wr && (req.idx == `UFP_IDX_FLAG) && req.wdata[`UFP_F_TXPEND]) begin
        tx_done_pending_flag <= 1'b0;
      end
    end
  end

  // ========================================================
  // Receiver
  assign rx_fin = rx_bit_end && (rx_state_reg == UFP_STOP) && rx_enable_bit;
  assign rx_data = char_length_bit ? rx_sh_reg : {1'b0, rx_sh_reg[7:1]};
  assign pe = ((parity_select_field == `UFP_PAR_EVEN) && (^rx_data ^ rx_par_reg))
    || ((parity_select_field == `UFP_PAR_ODD) && !(^rx_data ^ rx_par_reg));
  assign fe = !serial_in_pin;
  assign err_new = (pe ? `UFP_ERR_PE : 8'h00) | (fe ? `UFP_ERR_FE : 8'h00)
    | (rx_full_reg ? `UFP_ERR_OE : 8'h00);

  // Frame sequencer, aborted at once when receive is disabled
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state_reg <= UFP_IDLE;
      rx_cnt_reg <= `UFP_RST_8;
      rx_bit_reg <= 3'h0;
      rx_sh_reg <= `UFP_RST_8;
      rx_par_reg <= 1'b0;
      rx_prev_reg <= 1'b1;
    end else if (!rx_enable_bit) begin
      rx_state_reg <= UFP_IDLE;
      rx_prev_reg <= 1'b1;
    end else if (!clk_stop) begin
      if (tick) begin
        rx_cnt_reg <= rx_cnt_reg + 8'h01;
      end
      unique case (rx_state_reg)
        UFP_IDLE: begin
          rx_prev_reg <= serial_in_pin;
          if (rx_prev_reg && !serial_in_pin) begin
            rx_state_reg <= UFP_START;
            rx_cnt_reg <= 8'h00;
          end
        end
        UFP_START: begin
          if (rx_half_end) begin
            rx_cnt_reg <= 8'h00;
            rx_bit_reg <= 3'h0;
            rx_state_reg <= serial_in_pin ? UFP_IDLE : UFP_DATA;
          end
        end
        UFP_DATA: begin
          if (rx_bit_end) begin
            rx_cnt_reg <= 8'h00;
            rx_sh_reg <= {serial_in_pin, rx_sh_reg[7:1]};
            rx_bit_reg <= rx_bit_reg + 3'h1;
            if (rx_bit_reg == last_bit) begin
              rx_state_reg <= (parity_select_field == `UFP_PAR_NONE) ? UFP_STOP : UFP_PAR;
            end
          end
        end
        UFP_PAR: begin
          if (rx_bit_end) begin
            rx_cnt_reg <= 8'h00;
            rx_par_reg <= serial_in_pin;
            rx_state_reg <= UFP_STOP;
          end
        end
        UFP_STOP: begin
          if (rx_bit_end) begin
            rx_cnt_reg <= 8'h00;
            rx_prev_reg <= serial_in_pin;
            rx_state_reg <= UFP_IDLE;
          end
        end
      endcase
    end
  end

  // Buffer, status and full flag; a completing frame wins over a read
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_buffer_reg <= `UFP_RST_8;
      rx_error_status_reg <= `UFP_RST_8;
      rx_full_reg <= 1'b0;
    end else if (rx_fin) begin
      rx_buffer_reg <= rx_data;
      rx_error_status_reg <= err_new;
      rx_full_reg <= 1'b1;
    end else if (rxb_rd) begin
      rx_error_status_reg <= 8'h00;
      rx_full_reg <= 1'b0;
    end
  end

  // Error pulse first, done pulse one cycle later unless masked
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq.rx_error_irq <= 1'b0;
      irq.rx_done_irq <= 1'b0;
      done_dly_reg <= 1'b0;
      done_err_reg <= 1'b0;
    end else begin
      irq.rx_error_irq <= rx_fin && (err_new != 8'h00);
      done_dly_reg <= rx_fin;
      done_err_reg <= rx_fin && (err_new != 8'h00);
      irq.rx_done_irq <= done_dly_reg && !(done_err_reg && error_completion_mask);
    end
  end

  // ========================================================
  // Checks
  a_par_even: assert property (@(posedge core_clk) disable iff (!rst_n)
    tx_go && (parity_select_field == `UFP_PAR_EVEN) |=> tx_par_reg == ^tx_shift_reg)
    else $error("even parity bit wrong");
  a_par_odd: assert property (@(posedge core_clk) disable iff (!rst_n)
    tx_go && (parity_select_field == `UFP_PAR_ODD) |=> tx_par_reg != ^tx_shift_reg)
    else $error("odd parity bit wrong");
  a_par_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    (tx_state_reg == UFP_PAR) && (parity_select_field == `UFP_PAR_ZERO)
      && !$changed(tx_state_reg) |-> !serial_out_pin)
    else $error("zero parity bit not low");
  a_rx_parity: assert property (@(posedge core_clk) disable iff (!rst_n)
    rx_fin |=> rx_error_status_reg[2] == ($past(parity_select_field[1])
      && ($past(^rx_data ^ rx_par_reg) ^ !$past(parity_select_field[0]))))
    else $error("parity error flag wrong");
  a_rx_abort: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(rx_enable_bit) |=> (rx_state_reg == UFP_IDLE) && !irq.rx_error_irq
      && !irq.rx_done_irq ##1 !irq.rx_done_irq)
    else $error("receive not aborted");
  a_err_order: assert property (@(posedge core_clk) disable iff (!rst_n)
    irq.rx_error_irq |=> !irq.rx_error_irq ##0 (irq.rx_done_irq || error_completion_mask))
    else $error("error event not before done");
  a_done_mask: assert property (@(posedge core_clk) disable iff (!rst_n)
    irq.rx_done_irq |-> !($past(irq.rx_error_irq) && $past(error_completion_mask)))
    else $error("masked error frame raised done");
  a_rd_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    rxb_rd && !rx_fin |=> (rx_error_status_reg == 8'h00) && !rx_full_reg)
    else $error("status not cleared by read");
  a_idle_high: assert property (@(posedge core_clk) disable iff (!rst_n)
    (tx_state_reg == UFP_IDLE) && $past(tx_state_reg == UFP_IDLE) |-> serial_out_pin)
    else $error("idle line not high");
  a_stop_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_stop && $past(clk_stop) |-> $stable(serial_out_pin) && $stable(rx_state_reg))
    else $error("state moved during clock stop");
endmodule // uartfp_chan

// ==========================================================
// Top: AHB-Lite slave and two channels
module uartfp_top
  import uartfp_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic clk_stop,
  input wire logic [1:0] serial_in_pin,
  output logic [1:0] serial_out_pin,
  output logic [1:0][1:0] pin_serial,
  output uartfp_irq_s [1:0] irq
);
  logic rst_s1_reg;
  logic rst_n;
  logic act_reg;
  logic wr_reg;
  logic [31:0] addr_reg;
  logic mapped;
  logic [1:0][31:0] ch_rdata;

  // Reset release through two flip-flops
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n <= rst_s1_reg;
    end
  end

  // Address phase capture; one wait state then registered answer
  assign mapped = addr_reg[`UFP_MAP_HI:`UFP_MAP_LO] == 26'h0000000;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      act_reg <= 1'b0;
      wr_reg <= 1'b0;
      addr_reg <= 32'h00000000;
      hreadyout <= 1'b1;
      hrdata <= 32'h00000000;
      hresp <= 1'b0;
    end else if (act_reg) begin
      act_reg <= 1'b0;
      hreadyout <= 1'b1;
      hrdata <= (mapped && !wr_reg) ? ch_rdata[addr_reg[`UFP_CH_BIT]] : 32'h00000000;
    end else if (hsel && hready && htrans[1]) begin
      act_reg <= 1'b1;
      wr_reg <= hwrite;
      addr_reg <= haddr;
      hreadyout <= 1'b0;
    end
  end

  // Channel instances
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ch
      uartfp_req_s rq;
      assign rq.wr = act_reg && wr_reg && mapped && (addr_reg[`UFP_CH_BIT] == 1'(gi));
      assign rq.rd = act_reg && !wr_reg && mapped && (addr_reg[`UFP_CH_BIT] == 1'(gi));
      assign rq.idx = addr_reg[`UFP_IDX_HI:`UFP_IDX_LO];
      assign rq.wdata = hwdata;
      uartfp_chan u_ch (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_stop(clk_stop),
        .req(rq),
        .rdata(ch_rdata[gi]),
        .serial_in_pin(serial_in_pin[gi]),
        .serial_out_pin(serial_out_pin[gi]),
        .pin_serial(pin_serial[gi]),
        .irq(irq[gi])
      );
    end
  endgenerate
endmodule // uartfp_top
`default_nettype wire

// File: dv/uartfp_peer.sv
`timescale 1ns/1ps
`default_nettype none
// ========
// Remote serial peer: sends frames on request, captures what it hears
module uartfp_peer #(
  parameter int BT = 16
) (
  input wire logic core_clk,
  input wire logic line_in,
  output logic line_out
);
  logic [10:0] cap_q[$];
  logic [10:0] cap;
  // Line rests high between frames
  initial line_out = 1'h1;
  // Low start bit, then the given bits LSB first, then back to idle
  task automatic send(input logic [10:0] fr, input int n);
    line_out <= 1'h0;
    repeat (BT) @(posedge core_clk);
    for (int i = 0; i < n; i++) begin
      line_out <= fr[i];
      repeat (BT) @(posedge core_clk);
    end
    line_out <= 1'h1;
    @(posedge core_clk);
  endtask
  // Mid-bit sampling of eleven bits after a confirmed start bit
  always begin
    @(negedge line_in);
    repeat (BT / 2) @(posedge core_clk);
    if (line_in === 1'h0) begin
      for (int i = 0; i < 11; i++) begin
        repeat (BT) @(posedge core_clk);
        cap[i] = line_in;
      end
      cap_q.push_back(cap);
    end
  end
endmodule // uartfp_peer
`default_nettype wire

// File: dv/uartfp_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ========
// Bench for the two-channel serial core
module uartfp_tb;
  import uartfp_pkg::*;
  logic core_clk = 1'h0;
  logic nrst = 1'h0;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic clk_stop = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] q;
  logic hreadyout;
  logic hresp;
  logic p_line;
  logic bad;
  logic [1:0] sout;
  logic [1:0][1:0] pins;
  uartfp_irq_s [1:0] irq;
  logic [10:0] fr;
  logic [7:0] d;
  int mismatches = 0;
  int comparisons = 0;
  int seed = 45969;
  int n_err = 0;
  int n_done = 0;
  int n_tx = 0;
  int fn;
  int e0;
  int c0;
  time t_err = 0;
  time t_done = 0;
  // Main clock, 4 ns period
  always #2 core_clk = ~core_clk;
  uartfp_top dut (.core_clk(core_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .clk_stop(clk_stop),
    .serial_in_pin({sout[1], p_line}), .serial_out_pin(sout), .pin_serial(pins), .irq(irq));
  uartfp_peer #(.BT(16)) peer (.core_clk(core_clk), .line_in(sout[0]), .line_out(p_line));
  // Receive and transmit event counters for channel 0
  always @(posedge core_clk) begin
    if (irq[0].rx_error_irq === 1'h1) begin
      n_err++;
      t_err = $time;
    end
    if (irq[0].rx_done_irq === 1'h1) begin
      n_done++;
      t_done = $time;
    end
    if (irq[0].tx_done_irq === 1'h1) n_tx++;
  end
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One single AHB-Lite transfer; read data lands in q
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge core_clk);
    while (hreadyout !== 1'h1) @(posedge core_clk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge core_clk);
    while (hreadyout !== 1'h1) @(posedge core_clk);
    q = hrdata;
  endtask
  // Reference frame after the start bit; length goes to fn
  function automatic logic [10:0] frame(input int pm, input int nb, input logic [7:0] dd,
                                        input logic bp, input logic stp);
    logic [10:0] f;
    f = {3'h0, dd} & ((11'h1 << nb) - 11'h1);
    fn = nb + 1;
    if (pm != 0) begin
      f[nb] = (pm == 3 ? ^f : pm == 2 ? ~^f : 1'h0) ^ bp;
      fn = nb + 2;
    end
    f[fn - 1] = stp;
    return f;
  endfunction
  // Peer sends a frame, optionally cut short by disabling reception
  task automatic rx_frame(input logic [7:0] ed, input logic [7:0] ee, input int dn,
                          input logic ab);
    e0 = n_err;
    c0 = n_done;
    fork
      peer.send(fr, fn);
      if (ab) begin
        repeat (60) @(posedge core_clk);
        bus(1'h1, 32'h0, 32'h88);
      end
    join
    repeat (10) @(posedge core_clk);
    chk(n_err - e0, {31'h0, ee != 8'h0});
    chk(n_done - c0, dn);
    if (ee != 8'h0 && dn != 0) chk({31'h0, t_err < t_done}, 32'h1);
    bus(1'h0, 32'h0C, 32'h0);
    chk(q, {24'h0, ee});
    bus(1'h0, 32'h08, 32'h0);
    chk(q, {24'h0, ed});
    bus(1'h0, 32'h0C, 32'h0);
    chk(q, 32'h0);
  endtask
  // Verdict and end of run
  task automatic test_done();
    if (mismatches == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    repeat (40000) @(posedge core_clk);
    mismatches++;
    test_done();
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge core_clk);
    nrst <= 1'h1;
    repeat (4) @(posedge core_clk);
    chk({30'h0, sout}, 32'h3);
    chk({26'h0, irq}, 32'h0);
    bus(1'h1, 32'h10, 32'h8);
    bus(1'h0, 32'h18, 32'h0);
    chk(q, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    for (int pm = 0; pm < 4; pm++) begin
      for (int cl = 0; cl < 2; cl++) begin
        bus(1'h1, 32'h0, {24'h0, 2'h3, pm[1:0], cl[0], cl[0], 2'h0});
        d = $random(seed);
        bus(1'h1, 32'h04, {24'h0, d});
        for (int i = 0; i < 400 && peer.cap_q.size() == 0; i++) @(posedge core_clk);
        fr = frame(pm, 7 + cl, d, 1'h0, 1'h1);
        chk(peer.cap_q.pop_front() & ((11'h1 << fn) - 11'h1), fr);
        repeat (16) @(posedge core_clk);
        bus(1'h0, 32'h14, 32'h0);
        chk(q[0], 1'h1);
        chk(n_tx, 2 * pm + cl + 1);
        chk({30'h0, pins[0]}, 32'h3);
        bus(1'h1, 32'h14, 32'h1);
        d = $random(seed);
        bad = 1'($random(seed));
        fr = frame(pm, 7 + cl, d, bad, 1'h1);
        rx_frame(cl ? d : d & 8'h7F, (pm >= 2 && bad) ? 8'h04 : 8'h0, 1, 1'h0);
      end
    end
    // Missing stop bit with the completion mask set
    bus(1'h1, 32'h0, 32'hFA);
    d = $random(seed);
    fr = frame(3, 8, d, 1'h0, 1'h0);
    rx_frame(d, 8'h02, 0, 1'h0);
    // Second frame before the buffer is read
    bus(1'h1, 32'h0, 32'hC8);
    fr = frame(0, 8, 8'hA5, 1'h0, 1'h1);
    peer.send(fr, fn);
    d = $random(seed);
    fr = frame(0, 8, d, 1'h0, 1'h1);
    rx_frame(d, 8'h01, 1, 1'h0);
    // Reception switched off mid-frame
    fr = frame(0, 8, 8'h3C, 1'h0, 1'h1);
    rx_frame(d, 8'h0, 0, 1'h1);
    chk({30'h0, pins[0]}, 32'h2);
    // Channel 1 looped back on itself
    bus(1'h1, 32'h30, 32'h8);
    bus(1'h1, 32'h20, 32'hF8);
    d = $random(seed);
    bus(1'h1, 32'h24, {24'h0, d});
    chk({30'h0, pins[1]}, 32'h3);
    // Clock stopped mid-frame: line holds, reception resumes afterwards
    repeat (100) @(posedge core_clk);
    clk_stop <= 1'h1;
    @(posedge core_clk);
    c0 = sout[1];
    repeat (200) @(posedge core_clk);
    chk({31'h0, sout[1]}, c0);
    clk_stop <= 1'h0;
    repeat (200) @(posedge core_clk);
    bus(1'h0, 32'h28, 32'h0);
    chk(q, {24'h0, d});
    test_done();
  end
endmodule // uartfp_tb
`default_nettype wire
